// ==== hw/sacr_pkg.sv ====
// constants, register map and field layouts for the analog configuration bank
// assumes a classic wishbone slave with 32-bit data, word-aligned registers
package sacr_pkg;

	localparam int SACR_DW = 16;
	localparam int SACR_AW = 10;

	// ===========================================================
	// register word indices; byte address is four times the index
	localparam logic [7:0] SACR_IDX_CORE = 8'h28;
	localparam logic [7:0] SACR_IDX_LEVEL = 8'h29;
	localparam logic [7:0] SACR_IDX_FE_PWR = 8'h30;
	localparam logic [7:0] SACR_IDX_REF_PWR = 8'h40;
	localparam logic [7:0] SACR_IDX_REF_CUR = 8'h41;
	localparam logic [7:0] SACR_IDX_FE_CUR = 8'h42;
	localparam logic [7:0] SACR_IDX_MUX_CUR = 8'h43;

	// ===========================================================
	// reset values
	localparam logic [15:0] SACR_RST_CORE = 16'h0000;
	localparam logic [15:0] SACR_RST_LEVEL = 16'h0b5a;
	localparam logic [15:0] SACR_RST_FE_PWR = 16'h0000;
	localparam logic [15:0] SACR_RST_REF_PWR = 16'h0000;
	localparam logic [15:0] SACR_RST_REF_CUR = 16'h888b;
	localparam logic [15:0] SACR_RST_FE_CUR = 16'h53c8;
	localparam logic [15:0] SACR_RST_MUX_CUR = 16'h8888;

	// ===========================================================
	// writable bit masks; bits outside a mask keep their reset value
	localparam logic [15:0] SACR_MSK_CORE = 16'h0007;
	localparam logic [15:0] SACR_MSK_LEVEL = 16'hffff;
	localparam logic [15:0] SACR_MSK_FE_PWR = 16'h0001;
	localparam logic [15:0] SACR_MSK_REF_PWR = 16'h0001;
	localparam logic [15:0] SACR_MSK_REF_CUR = 16'hffff;
	localparam logic [15:0] SACR_MSK_FE_CUR = 16'h7fff;
	localparam logic [15:0] SACR_MSK_MUX_CUR = 16'h0fff;

	// ===========================================================
	// field positions
	localparam int SACR_B_CORE_PWR = 0;
	localparam int SACR_B_MUX_PWR = 1;
	localparam int SACR_B_COLBIAS_EN = 2;
	localparam int SACR_B_TESTPAT = 13;
	localparam int SACR_B_INJECT = 14;
	localparam int SACR_B_EXT_RES = 0;

	// analog control outputs grouped for the pins of the analog core
	typedef struct packed {
		logic core_power_up;
		logic selector_power_up;
		logic column_bias_enable;
		logic [3:0] second_slope_reset_level;
		logic [3:0] third_slope_reset_level;
		logic [2:0] antibloom_level;
		logic [1:0] cascode_supply_level;
		logic test_pattern_enable;
		logic test_inject_level;
		logic frontend_power_up;
		logic reference_power_up;
		logic external_resistor_sel;
		logic [3:0] precharge_current_trim;
		logic [3:0] column_bias_trim;
		logic [3:0] pump_current_trim;
		logic [3:0] frontend_bias_trim;
		logic [3:0] converter_ref_trim;
		logic [6:0] amplifier_ref_trim;
		logic [3:0] selector_first_stage_trim;
		logic [3:0] selector_second_stage_trim;
		logic [3:0] selector_delay_trim;
	} sacr_analog_s;

endpackage

// ==== hw/sacr_reg16.sv ====
// one 16-bit configuration register with write mask and reset value
// assumes a synchronous active-high reset and a one-cycle write strobe
`timescale 1ns/1ns
module sacr_reg16 #(
	parameter logic [15:0] RESET_VAL = 16'h0000,
	parameter logic [15:0] MASK = 16'hffff
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_we,
	input wire logic [1:0] i_sel,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_value
);

	logic [15:0] value_q;
	logic [15:0] lane_mask;
	logic [15:0] value_d;

	assign lane_mask = {{8{i_sel[1]}}, {8{i_sel[0]}}} & MASK;
	assign value_d = (value_q & ~lane_mask) | (i_wdata & lane_mask);

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			value_q <= RESET_VAL;
		else if (i_we)
			value_q <= value_d;
	end

	assign o_value = value_q;

endmodule // sacr_reg16

// ==== hw/sacr_regs.sv ====
// analog configuration register bank behind a classic wishbone slave
// assumes 32-bit wishbone data, byte address, one clock, synchronous reset
`timescale 1ns/1ns
module sacr_regs #(
	parameter int ADDR_W = sacr_pkg::SACR_AW
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [ADDR_W-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic o_wb_err,
	output sacr_pkg::sacr_analog_s o_analog
);
	import sacr_pkg::*;

	localparam int NREG = 7;

	// ===========================================================
	// parameter check
	if (ADDR_W < 10)
	begin : g_bad_aw
		$error("address width must reach the highest register");
	end

	// ===========================================================
	// decode table and bank positions
	typedef logic [7:0] sacr_idx_t;
	localparam sacr_idx_t IDX [NREG] = '{
		SACR_IDX_CORE,
		SACR_IDX_LEVEL,
		SACR_IDX_FE_PWR,
		SACR_IDX_REF_PWR,
		SACR_IDX_REF_CUR,
		SACR_IDX_FE_CUR,
		SACR_IDX_MUX_CUR
	};
	localparam int R_CORE = 0;
	localparam int R_LEVEL = 1;
	localparam int R_FE_PWR = 2;
	localparam int R_REF_PWR = 3;
	localparam int R_REF_CUR = 4;
	localparam int R_FE_CUR = 5;
	localparam int R_MUX_CUR = 6;

	// ===========================================================
	// map checks
	// the register cells are sixteen bits wide
	if (SACR_DW != 16)
	begin : g_bad_dw
		$error("register width must be sixteen bits");
	end
	// two registers on one word would both take a write and clash on reads
	for (genvar a = 0; a < NREG; a++)
	begin : g_chk_a
		for (genvar b = a + 1; b < NREG; b++)
		begin : g_chk_b
			if (IDX[a] == IDX[b])
			begin : g_dup
				$error("two registers share one word index");
			end
		end
	end

	// ===========================================================
	// declarations
	wire logic req;
	wire logic upper_clear;
	wire logic lane_clear;
	wire logic aligned;
	wire logic [7:0] word_idx;
	wire logic [NREG-1:0] hit;
	wire logic mapped;
	wire logic take_ok;
	wire logic take_bad;
	wire logic take_read;
	wire logic wr_en;
	wire logic [NREG-1:0] wr_hit;
	wire logic [1:0] wr_sel;
	wire logic [15:0] wr_data;
	wire logic [15:0] value [NREG];
	wire logic [15:0] rd_term [NREG];
	wire logic [15:0] rd_chain [NREG+1];
	logic ack_q;
	logic err_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [15:0] rmux;
	sacr_analog_s analog_q;
	sacr_analog_s analog_d;

	// ===========================================================
	// request qualification
	// the answer cycle masks the strobe so a held request is not taken twice
	assign req = i_wb_cyc & i_wb_stb & ~ack_q & ~err_q;
	// address bits above the decoded window must be clear
	assign upper_clear = ((i_wb_adr >> 10) == '0);
	// registers are word aligned; byte offsets inside a word are refused
	assign lane_clear = (i_wb_adr[1:0] == 2'h0);
	assign aligned = upper_clear & lane_clear;
	assign word_idx = i_wb_adr[9:2];

	// ===========================================================
	// address decode, one compare per register
	assign hit[R_CORE] = (word_idx == IDX[R_CORE]);
	assign hit[R_LEVEL] = (word_idx == IDX[R_LEVEL]);
	assign hit[R_FE_PWR] = (word_idx == IDX[R_FE_PWR]);
	assign hit[R_REF_PWR] = (word_idx == IDX[R_REF_PWR]);
	assign hit[R_REF_CUR] = (word_idx == IDX[R_REF_CUR]);
	assign hit[R_FE_CUR] = (word_idx == IDX[R_FE_CUR]);
	assign hit[R_MUX_CUR] = (word_idx == IDX[R_MUX_CUR]);
	assign mapped = aligned & (|hit);
	assign take_ok = req & mapped;
	assign take_bad = req & ~mapped;
	assign take_read = take_ok & ~i_wb_we;

	// ===========================================================
	// write strobes
	// only the low two byte lanes reach the sixteen-bit cells
	assign wr_en = take_ok & i_wb_we;
	assign wr_hit = hit & {NREG{wr_en}};
	assign wr_sel = i_wb_sel[1:0];
	assign wr_data = i_wb_dat[15:0];

	// ===========================================================
	// register cells
	// a write lands on the edge that takes the request; ack rises on that same edge
	// core and column power
	sacr_reg16 #(
		.RESET_VAL(SACR_RST_CORE),
		.MASK(SACR_MSK_CORE)
	) u_core (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_we(wr_hit[R_CORE]),
		.i_sel(wr_sel),
		.i_wdata(wr_data),
		.o_value(value[R_CORE])
	);

	sacr_reg16 #(
		.RESET_VAL(SACR_RST_LEVEL),
		.MASK(SACR_MSK_LEVEL)
	) u_level (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_we(wr_hit[R_LEVEL]),
		.i_sel(wr_sel),
		.i_wdata(wr_data),
		.o_value(value[R_LEVEL])
	);

	sacr_reg16 #(
		.RESET_VAL(SACR_RST_FE_PWR),
		.MASK(SACR_MSK_FE_PWR)
	) u_fe_pwr (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_we(wr_hit[R_FE_PWR]),
		.i_sel(wr_sel),
		.i_wdata(wr_data),
		.o_value(value[R_FE_PWR])
	);

	sacr_reg16 #(
		.RESET_VAL(SACR_RST_REF_PWR),
		.MASK(SACR_MSK_REF_PWR)
	) u_ref_pwr (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_we(wr_hit[R_REF_PWR]),
		.i_sel(wr_sel),
		.i_wdata(wr_data),
		.o_value(value[R_REF_PWR])
	);

	sacr_reg16 #(
		.RESET_VAL(SACR_RST_REF_CUR),
		.MASK(SACR_MSK_REF_CUR)
	) u_ref_cur (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_we(wr_hit[R_REF_CUR]),
		.i_sel(wr_sel),
		.i_wdata(wr_data),
		.o_value(value[R_REF_CUR])
	);

	// front end current trims
	sacr_reg16 #(
		.RESET_VAL(SACR_RST_FE_CUR),
		.MASK(SACR_MSK_FE_CUR)
	) u_fe_cur (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_we(wr_hit[R_FE_CUR]),
		.i_sel(wr_sel),
		.i_wdata(wr_data),
		.o_value(value[R_FE_CUR])
	);

	sacr_reg16 #(
		.RESET_VAL(SACR_RST_MUX_CUR),
		.MASK(SACR_MSK_MUX_CUR)
	) u_mux_cur (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_we(wr_hit[R_MUX_CUR]),
		.i_sel(wr_sel),
		.i_wdata(wr_data),
		.o_value(value[R_MUX_CUR])
	);

	// ===========================================================
	// read selection
	// readback as stored
	// hits are one-hot, so the OR chain acts as a plain multiplexer
	for (genvar g = 0; g < NREG; g++)
	begin : g_rd
		assign rd_term[g] = hit[g] ? value[g] : 16'h0000;
		assign rd_chain[g + 1] = rd_chain[g] | rd_term[g];
	end
	assign rd_chain[0] = 16'h0000;
	assign rmux = rd_chain[NREG];
	// refused requests and writes return zero data
	assign rdata_d = take_read ? {16'h0000, rmux} : 32'h0000_0000;

	// ===========================================================
	// field mapping onto analog controls
	always_comb
	begin
		analog_d.core_power_up = value[0][SACR_B_CORE_PWR];
		analog_d.selector_power_up = value[0][SACR_B_MUX_PWR];
		analog_d.column_bias_enable = value[0][SACR_B_COLBIAS_EN];
		analog_d.second_slope_reset_level = value[1][3:0];
		analog_d.third_slope_reset_level = value[1][7:4];
		analog_d.antibloom_level = value[1][10:8];
		analog_d.cascode_supply_level = value[1][12:11];
		analog_d.test_pattern_enable = value[1][SACR_B_TESTPAT];
		analog_d.test_inject_level = value[1][SACR_B_INJECT];
		analog_d.frontend_power_up = value[2][0];
		analog_d.reference_power_up = value[3][0];
		analog_d.external_resistor_sel = value[4][SACR_B_EXT_RES];
		analog_d.precharge_current_trim = value[4][7:4];
		analog_d.column_bias_trim = value[4][11:8];
		analog_d.pump_current_trim = value[4][15:12];
		analog_d.frontend_bias_trim = value[5][3:0];
		analog_d.converter_ref_trim = value[5][7:4];
		analog_d.amplifier_ref_trim = value[5][14:8];
		analog_d.selector_first_stage_trim = value[6][3:0];
		analog_d.selector_second_stage_trim = value[6][7:4];
		analog_d.selector_delay_trim = value[6][11:8];
	end

	// ===========================================================
	// bus answer
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			analog_q <= '0;
		end
		else
		begin
			// a refused request gets err instead of ack
			ack_q <= take_ok;
			err_q <= take_bad;
			rdata_q <= rdata_d;
			analog_q <= analog_d;
		end
	end

	assign o_wb_ack = ack_q;
	assign o_wb_err = err_q;
	assign o_wb_dat = rdata_q;
	assign o_analog = analog_q;

endmodule // sacr_regs

// ==== sim/sacr_regs_sva.sv ====
// assertions on the analog configuration bank ports
// assumes it is bound into sacr_regs, one clock, synchronous reset
`timescale 1ns/1ns
module sacr_regs_sva #(parameter int ADDR_W = 10) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [ADDR_W-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic o_wb_err,
	input wire sacr_pkg::sacr_analog_s o_analog
);
	import sacr_pkg::*;
	// ============================================================
	// bus answers and analog field tracking
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	wire logic tk = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~o_wb_err;
	wire logic [15:0] d = i_wb_dat[15:0];
	wire sacr_analog_s q = o_analog;
	sequence s_wr(a, s);
		tk && i_wb_we && i_wb_adr == a && i_wb_sel[s];
	endsequence
	property p_ans; tk |=> o_wb_ack ^ o_wb_err; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_pulse; o_wb_ack |=> !o_wb_ack; endproperty
	a_pulse: assert property (p_pulse) else $error("ack held");
	property p_mis; tk && i_wb_adr[1:0] != 2'h0 |=> o_wb_err; endproperty
	a_mis: assert property (p_mis) else $error("misaligned taken");
	property p_idle; !o_wb_ack |-> o_wb_dat == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("data not idle");
	property p_core; s_wr(10'h0a0,0) |=> ##1 q.core_power_up==$past(d[0],2); endproperty
	a_core: assert property (p_core) else $error("core power");
	property p_mux; s_wr(10'h0a0,0) |=> ##1 q.selector_power_up==$past(d[1],2); endproperty
	a_mux: assert property (p_mux) else $error("mux power");
	property p_tp; s_wr(10'h0a4,1) |=> ##1 q.test_pattern_enable==$past(d[13],2); endproperty
	a_tp: assert property (p_tp) else $error("test pattern");
	property p_ext; s_wr(10'h104,0) |=> ##1 q.external_resistor_sel==$past(d[0],2); endproperty
	a_ext: assert property (p_ext) else $error("resistor select");
endmodule // sacr_regs_sva
bind sacr_regs sacr_regs_sva #(.ADDR_W(ADDR_W)) u_sva (.i_mclk, .i_reset, .i_wb_cyc, .i_wb_stb,
	.i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_wb_err, .o_analog);

// ==== sim/sensor_analog_config_regs_bench.sv ====
// self-checking bench for the analog configuration bank
// assumes sacr_regs answers each wishbone request within a few cycles
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
	$display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
module sensor_analog_config_regs_bench;
	import sacr_pkg::*;
	// ============================================================
	// stimulus, design and register rows
	logic i_mclk = 1'h0, i_reset = 1'h1, cs = 1'h0, i_wb_we = 1'h0;
	logic [9:0] i_wb_adr = 10'h0;
	logic [3:0] i_wb_sel = 4'h0;
	logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
	logic o_wb_ack, o_wb_err;
	logic [16:0] rs;
	sacr_analog_s q;
	int errors = 0, checked = 0;
	logic [9:0] ra [7] = '{10'h0a0, 10'h0a4, 10'h0c0, 10'h100, 10'h104, 10'h108, 10'h10c};
	logic [15:0] rv [7] = '{16'h0, 16'hb5a, 16'h0, 16'h0, 16'h888b, 16'h53c8, 16'h8888};
	logic [15:0] mk [7] = '{16'h7, 16'hffff, 16'h1, 16'h1, 16'hffff, 16'h7fff, 16'hfff};
	always #5 i_mclk = ~i_mclk;
	sacr_regs #(.ADDR_W(10)) uut (.i_mclk, .i_reset, .i_wb_cyc(cs), .i_wb_stb(cs), .i_wb_we,
		.i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_wb_err, .o_analog(q));
	task automatic tally_and_finish();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [9:0] a, input logic [15:0] v,
		input logic [3:0] s);
		int n;
		logic done;
		n = 0;
		done = 1'h0;
		@(posedge i_mclk);
		cs <= 1'h1;
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_sel <= s;
		i_wb_dat <= {16'h0, v};
		// answer is sampled at the rising edge, before the design's update lands
		while (!done && n < 20)
		begin
			@(posedge i_mclk);
			n++;
			done = (o_wb_ack === 1'h1) || (o_wb_err === 1'h1);
		end
		rs = {o_wb_err, o_wb_dat[15:0]};
		cs <= 1'h0;
		errors += !done;
		if (!done)
			tally_and_finish();
	endtask
	// two-cycle reset, then every register and the slope, antibloom and cascode levels show defaults
	task automatic rst_chk();
		i_reset <= 1'h1;
		repeat (2) @(posedge i_mclk);
		i_reset <= 1'h0;
		foreach (ra[i])
		begin
			wb(1'h0, ra[i], 16'h0, 4'h3);
			`CHK(rs, {1'h0, rv[i]})
		end
		`CHK({q.second_slope_reset_level, q.third_slope_reset_level, q.antibloom_level,
			q.cascode_supply_level, q.external_resistor_sel, q.precharge_current_trim}, 18'h295b8)
	endtask
	initial
	begin
		rst_chk();
		foreach (ra[i])
		begin
			wb(1'h1, ra[i], ~rv[i], 4'h3);
			wb(1'h0, ra[i], 16'h0, 4'h3);
			`CHK(rs, {1'h0, (~rv[i] & mk[i]) | (rv[i] & ~mk[i])})
		end
		`CHK({q.core_power_up, q.selector_power_up, q.test_pattern_enable, q.test_inject_level,
			q.frontend_power_up, q.reference_power_up, q.external_resistor_sel,
			q.pump_current_trim, q.selector_delay_trim}, 15'h7e77)
		`CHK({q.column_bias_enable, q.selector_first_stage_trim, q.selector_second_stage_trim,
			q.frontend_bias_trim, q.converter_ref_trim, q.amplifier_ref_trim}, 24'hbbb9ac)
		// misaligned write must leave the core register alone
		wb(1'h1, 10'h0a2, 16'h0, 4'h3);
		`CHK(rs, 17'h10000)
		wb(1'h0, 10'h0a0, 16'h0, 4'h3);
		`CHK(rs, 17'h7)
		wb(1'h0, 10'h0a8, 16'h0, 4'h3);
		`CHK(rs, 17'h10000)
		// byte lanes write one half each
		wb(1'h1, 10'h10c, 16'h0, 4'h2);
		wb(1'h1, 10'h10c, 16'h0505, 4'h1);
		wb(1'h0, 10'h10c, 16'h0, 4'h3);
		`CHK(rs, 17'h08005)
		rst_chk();
		tally_and_finish();
	end
endmodule // sensor_analog_config_regs_bench
